// ---- core/sleep_clk_gate_params.svh ----
/*
  offsets, field positions, reset values and timing counts of the
  sleep gating, kernel source and backup domain control registers.
  assumes: included by bare name from the design files.
*/
`ifndef SLEEP_CLK_GATE_PARAMS_SVH
`define SLEEP_CLK_GATE_PARAMS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define OFF_SLEEP_GATE 12'h050
`define OFF_KERNEL_SEL 12'h054
`define OFF_BACKUP_CTL 12'h05c

// ----------------------------------------------------------------
// reset values and writable masks
// ----------------------------------------------------------------
`define RST_SLEEP_GATE 32'h0017d801
`define MSK_SLEEP_GATE 32'h0017d801
`define RST_KERNEL_SEL 32'h00000000
`define MSK_KERNEL_SEL 32'hc000f00f

// ----------------------------------------------------------------
// sleep gating bit positions
// ----------------------------------------------------------------
`define BIT_CONVERTER 20
`define BIT_TIMER_G   18
`define BIT_TIMER_F   17
`define BIT_TIMER_E   16
`define BIT_TIMER_D   15
`define BIT_SERIAL_A  14
`define BIT_SYNC_SER  12
`define BIT_ADV_TIMER 11
`define BIT_SYS_CFG   0

// ----------------------------------------------------------------
// kernel source field positions (low bit of each field)
// ----------------------------------------------------------------
`define POS_CONVERTER_SRC 30
`define POS_AUDIO_SRC     14
`define POS_TWO_WIRE_SRC  12
`define POS_SERIAL_B_SRC  2
`define POS_SERIAL_A_SRC  0

// ----------------------------------------------------------------
// backup domain control field positions
// ----------------------------------------------------------------
`define BIT_SLOW_OUT_SEL 25
`define BIT_SLOW_OUT_EN  24
`define BIT_DOMAIN_RST   16
`define BIT_CAL_EN       15
`define POS_CAL_SRC      8
`define BIT_FAIL_FLAG    6
`define BIT_MON_EN       5
`define POS_DRIVE        3
`define BIT_BYPASS       2
`define BIT_READY        1
`define BIT_XTAL_EN      0

// ----------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------
`define BACKUP_WAIT_STATES 2'd3
`define READY_DROP_EDGES   6

`endif

// ---- core/sleep_clk_gate_pkg.sv ----
/*
  types shared by the clock control slice.
  assumes: nothing beyond a SystemVerilog compiler.
*/
package sleep_clk_gate_pkg;

  // clock run enables of the gated peripherals
  typedef struct packed {
    logic converter;
    logic timer_g;
    logic timer_f;
    logic timer_e;
    logic timer_d;
    logic serial_port_a;
    logic sync_serial_a;
    logic advanced_timer;
    logic sys_config;
  } periph_run_type;

  // kernel clock source codes
  typedef struct packed {
    logic [1:0] converter_clk_source;
    logic [1:0] audio_serial_clk_source;
    logic [1:0] two_wire_clk_source;
    logic [1:0] serial_port_b_clk_source;
    logic [1:0] serial_port_a_clk_source;
  } kernel_sel_type;

  // backup domain control fields
  typedef struct packed {
    logic       slow_clk_out_select;
    logic       slow_clk_out_enable;
    logic       backup_domain_sw_reset;
    logic       calendar_clock_enable;
    logic [1:0] calendar_clock_source;
    logic       crystal_failure_flag;
    logic       crystal_monitor_enable;
    logic [1:0] crystal_drive_level;
    logic       crystal_bypass;
    logic       crystal_enable;
  } backup_ctrl_type;

  // ready tracker states, gray along off, ready, drain
  typedef enum logic [1:0] {
    XTAL_OFF   = 2'b00,
    XTAL_READY = 2'b01,
    XTAL_DRAIN = 2'b11
  } ready_state_type;

endpackage : sleep_clk_gate_pkg

// ---- core/pin_sync.sv ----
/*
  two flip-flop synchroniser for a group of level inputs.
  assumes: inputs come from outside the clock domain.
*/
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,   // system clock
  input  wire logic             rst_n_i, // async reset, low
  input  wire logic [WIDTH-1:0] async_i, // raw levels
  output logic      [WIDTH-1:0] sync_o   // synchronised levels
);

  logic [WIDTH-1:0] stage;

  // ----------------------------------------------------------------
  // two stages, the first read only by the second
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stage  <= '0;
      sync_o <= '0;
    end else begin
      stage  <= async_i;
      sync_o <= stage;
    end
  end

endmodule : pin_sync

// ---- core/crystal_ready_tracker.sv ----
/*
  crystal ready flag: rises when the oscillator reports stable with the enable set,
  falls a set number of crystal clock edges after the enable drops.
  assumes: stable and crystal clock already synchronised.
*/
`timescale 1ns/100ps
`include "sleep_clk_gate_params.svh"
module crystal_ready_tracker #(
  parameter int DROP_EDGES = `READY_DROP_EDGES
) (
  input  wire logic clk_i,    // system clock
  input  wire logic rst_n_i,  // domain power-on reset, low
  input  wire logic clear_i,  // software domain reset
  input  wire logic enable_i, // crystal enable bit
  input  wire logic stable_i, // oscillator stable, synced
  input  wire logic xclk_i,   // crystal clock, synced
  output logic      ready_o   // crystal ready flag
);

  typedef struct packed {
    sleep_clk_gate_pkg::ready_state_type state;
    logic [2:0]                          edges;
    logic                                xclk_prev;
  } tracker_state_type;

  tracker_state_type st;
  tracker_state_type next_st;
  logic              rise;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st           = st;
    rise              = xclk_i & ~st.xclk_prev;
    next_st.xclk_prev = xclk_i;
    case (st.state)
      sleep_clk_gate_pkg::XTAL_OFF: begin
        if (enable_i && stable_i) begin
          next_st.state = sleep_clk_gate_pkg::XTAL_READY;
        end
      end
      sleep_clk_gate_pkg::XTAL_READY: begin
        if (!enable_i) begin
          next_st.state = sleep_clk_gate_pkg::XTAL_DRAIN;
          next_st.edges = 3'd0;
        end
      end
      default: begin
        // count crystal edges after the enable drops
        if (enable_i) begin
          next_st.state = sleep_clk_gate_pkg::XTAL_READY;
        end else if (rise) begin
          if (st.edges == 3'(DROP_EDGES - 1)) begin
            next_st.state = sleep_clk_gate_pkg::XTAL_OFF;
          end
          next_st.edges = st.edges + 3'd1;
        end
      end
    endcase
    if (clear_i) begin
      next_st.state = sleep_clk_gate_pkg::XTAL_OFF;
      next_st.edges = 3'd0;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '{sleep_clk_gate_pkg::XTAL_OFF, 3'd0, 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign ready_o = (st.state != sleep_clk_gate_pkg::XTAL_OFF);

endmodule : crystal_ready_tracker

// ---- core/sleep_clk_gate_kernel_sel_rtc.sv ----
/*
  apb register slice: sleep clock gating, kernel clock sources and
  backup domain control with its own reset and write protection.
  assumes: apb master on the system clock; power controller and mode
  inputs synchronous; oscillator status pins asynchronous.
*/
`timescale 1ns/100ps
`include "sleep_clk_gate_params.svh"
module sleep_clk_gate_kernel_sel_rtc #(
  parameter int ADDR_W = 12
) (
  input  wire logic                               CLK_SYS_I,      // 25 mhz clock
  input  wire logic                               RESETN_I,       // system reset, low
  input  wire logic                               BKP_PORN_I,     // domain power-on, low
  input  wire logic                               PSEL_I,         // apb select
  input  wire logic                               PENABLE_I,      // apb enable
  input  wire logic                               PWRITE_I,       // apb write
  input  wire logic [ADDR_W-1:0]                  PADDR_I,        // apb byte address
  input  wire logic [31:0]                        PWDATA_I,       // apb write data
  input  wire logic [3:0]                         PSTRB_I,        // apb byte strobes
  output logic      [31:0]                        PRDATA_O,       // apb read data
  output logic                                    PREADY_O,       // apb ready
  output logic                                    PSLVERR_O,      // apb error
  input  wire logic                               DOMAIN_WRITE_UNLOCK_I, // unlock
  input  wire logic                               SLEEP_MODE_I,   // core in sleep
  input  wire logic                               STOP_MODE_I,    // core in stop
  input  wire logic                               XTAL_STABLE_I,  // osc stable pin
  input  wire logic                               XTAL_CLK_I,     // crystal clock pin
  input  wire logic                               XTAL_FAIL_I,    // monitor failure pin
  output sleep_clk_gate_pkg::periph_run_type      PERIPH_RUN_O,   // clock run enables
  output sleep_clk_gate_pkg::kernel_sel_type      KERNEL_SEL_O,   // kernel sources
  output sleep_clk_gate_pkg::backup_ctrl_type     BACKUP_CTRL_O,  // backup controls
  output logic                                    XTAL_READY_O,   // crystal ready
  output logic                                    DOMAIN_RESET_O  // domain reset
);

  // ----------------------------------------------------------------
  // state types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] sleep_gate;
    logic [31:0] kernel_sel;
    logic [1:0]  gap;
    logic [31:0] rdata;
  } core_state_type;

  core_state_type                      core;
  core_state_type                      next_core;
  sleep_clk_gate_pkg::backup_ctrl_type bk;
  sleep_clk_gate_pkg::backup_ctrl_type next_bk;

  logic [2:0]  pins_s;
  logic        stable_s;
  logic        xclk_s;
  logic        fail_s;
  logic        ready;
  logic        hit_gate;
  logic        hit_kern;
  logic        hit_bk;
  logic        mapped;
  logic        access;
  logic        done;
  logic        wr;
  logic [31:0] bk_word;
  logic [31:0] bk_new;
  logic [31:0] rd_mux;
  logic        locked;

  // merge write data into a word under byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  // ----------------------------------------------------------------
  // pin synchronisers and ready tracking
  // ----------------------------------------------------------------
  pin_sync #(
    .WIDTH (3)
  ) u_pin_sync (
    .clk_i   (CLK_SYS_I),
    .rst_n_i (BKP_PORN_I),
    .async_i ({XTAL_FAIL_I, XTAL_CLK_I, XTAL_STABLE_I}),
    .sync_o  (pins_s)
  );

  assign stable_s = pins_s[0];
  assign xclk_s   = pins_s[1];
  assign fail_s   = pins_s[2];

  crystal_ready_tracker #(
    .DROP_EDGES (`READY_DROP_EDGES)
  ) u_ready (
    .clk_i    (CLK_SYS_I),
    .rst_n_i  (BKP_PORN_I),
    .clear_i  (bk.backup_domain_sw_reset),
    .enable_i (bk.crystal_enable),
    .stable_i (stable_s),
    .xclk_i   (xclk_s),
    .ready_o  (ready)
  );

  // ----------------------------------------------------------------
  // address decode and handshake
  // ----------------------------------------------------------------
  always_comb begin
    hit_gate = 1'b0;
    hit_kern = 1'b0;
    hit_bk   = 1'b0;
    if (PADDR_I == ADDR_W'(`OFF_SLEEP_GATE)) begin
      hit_gate = 1'b1;
    end else if (PADDR_I == ADDR_W'(`OFF_KERNEL_SEL)) begin
      hit_kern = 1'b1;
    end else if (PADDR_I == ADDR_W'(`OFF_BACKUP_CTL)) begin
      hit_bk = 1'b1;
    end
  end

  assign mapped    = hit_gate | hit_kern | hit_bk;
  assign access    = PSEL_I & PENABLE_I;
  // backup accesses wait out the gap left by the previous one
  assign PREADY_O  = ~hit_bk | (core.gap == 2'd0);
  assign done      = access & PREADY_O;
  assign wr        = done & PWRITE_I & mapped;
  assign PSLVERR_O = access & ~mapped;

  // ----------------------------------------------------------------
  // backup register as a word
  // ----------------------------------------------------------------
  always_comb begin
    bk_word                                 = 32'h00000000;
    bk_word[`BIT_SLOW_OUT_SEL]              = bk.slow_clk_out_select;
    bk_word[`BIT_SLOW_OUT_EN]               = bk.slow_clk_out_enable;
    bk_word[`BIT_DOMAIN_RST]                = bk.backup_domain_sw_reset;
    bk_word[`BIT_CAL_EN]                    = bk.calendar_clock_enable;
    bk_word[`POS_CAL_SRC +: 2]              = bk.calendar_clock_source;
    bk_word[`BIT_FAIL_FLAG]                 = bk.crystal_failure_flag;
    bk_word[`BIT_MON_EN]                    = bk.crystal_monitor_enable;
    bk_word[`POS_DRIVE +: 2]                = bk.crystal_drive_level;
    bk_word[`BIT_BYPASS]                    = bk.crystal_bypass;
    bk_word[`BIT_READY]                     = ready;
    bk_word[`BIT_XTAL_EN]                   = bk.crystal_enable;
  end

  // read multiplexer, unmapped reads give zero
  always_comb begin
    rd_mux = 32'h00000000;
    if (hit_gate) begin
      rd_mux = core.sleep_gate;
    end else if (hit_kern) begin
      rd_mux = core.kernel_sel;
    end else if (hit_bk) begin
      rd_mux = bk_word;
    end
  end

  // ----------------------------------------------------------------
  // system-reset registers, next state
  // ----------------------------------------------------------------
  always_comb begin
    next_core       = core;
    next_core.rdata = rd_mux;
    if (wr && hit_gate) begin
      next_core.sleep_gate = merge(core.sleep_gate, PWDATA_I, PSTRB_I)
                             & `MSK_SLEEP_GATE;
    end
    if (wr && hit_kern) begin
      next_core.kernel_sel = merge(core.kernel_sel, PWDATA_I, PSTRB_I)
                             & `MSK_KERNEL_SEL;
    end
    // open a wait gap after each backup access
    if (done && hit_bk) begin
      next_core.gap = `BACKUP_WAIT_STATES;
    end else if (core.gap != 2'd0) begin
      next_core.gap = core.gap - 2'd1;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      core <= '{`RST_SLEEP_GATE, `RST_KERNEL_SEL, 2'd0, 32'h00000000};
    end else begin
      core <= next_core;
    end
  end

  assign PRDATA_O = core.rdata;

  // ----------------------------------------------------------------
  // backup domain register, next state
  // ----------------------------------------------------------------
  assign bk_new = merge(bk_word, PWDATA_I, PSTRB_I);
  assign locked = (bk.calendar_clock_source != 2'b00)
                  & ~bk.crystal_failure_flag;

  always_comb begin
    next_bk = bk;
    // writes only land once the power controller unlocks the domain
    if (wr && hit_bk && DOMAIN_WRITE_UNLOCK_I) begin
      next_bk.slow_clk_out_select    = bk_new[`BIT_SLOW_OUT_SEL];
      next_bk.slow_clk_out_enable    = bk_new[`BIT_SLOW_OUT_EN];
      next_bk.backup_domain_sw_reset = bk_new[`BIT_DOMAIN_RST];
      next_bk.calendar_clock_enable  = bk_new[`BIT_CAL_EN];
      next_bk.crystal_drive_level    = bk_new[`POS_DRIVE +: 2];
      next_bk.crystal_enable         = bk_new[`BIT_XTAL_EN];
      if (!locked) begin
        next_bk.calendar_clock_source = bk_new[`POS_CAL_SRC +: 2];
      end
      // enable sticks unless a failure has been flagged
      if (bk_new[`BIT_MON_EN] || bk.crystal_failure_flag) begin
        next_bk.crystal_monitor_enable = bk_new[`BIT_MON_EN];
      end
      if (!bk.crystal_enable && !ready) begin
        next_bk.crystal_bypass = bk_new[`BIT_BYPASS];
      end
    end
    // software domain reset clears all but the power-on-only bits
    if (bk.backup_domain_sw_reset) begin
      next_bk.calendar_clock_enable  = 1'b0;
      next_bk.calendar_clock_source  = 2'b00;
      next_bk.crystal_failure_flag   = 1'b0;
      next_bk.crystal_monitor_enable = 1'b0;
      next_bk.crystal_drive_level    = 2'b00;
      next_bk.crystal_bypass         = 1'b0;
      next_bk.crystal_enable         = 1'b0;
    end
    // failure set by the monitor wins over any clear
    if (bk.crystal_monitor_enable && fail_s) begin
      next_bk.crystal_failure_flag = 1'b1;
    end
  end

  // only the domain power-on clears this state, system reset never
  always_ff @(posedge CLK_SYS_I or negedge BKP_PORN_I) begin
    if (!BKP_PORN_I) begin
      bk <= '0;
    end else begin
      bk <= next_bk;
    end
  end

  // ----------------------------------------------------------------
  // clock run enables in sleep and stop
  // ----------------------------------------------------------------
  always_comb begin
    PERIPH_RUN_O = '1;
    if (SLEEP_MODE_I || STOP_MODE_I) begin
      // sleep-only clocks stop in stop mode
      PERIPH_RUN_O.converter      = SLEEP_MODE_I & ~STOP_MODE_I
                                    & core.sleep_gate[`BIT_CONVERTER];
      PERIPH_RUN_O.timer_g        = SLEEP_MODE_I & ~STOP_MODE_I
                                    & core.sleep_gate[`BIT_TIMER_G];
      PERIPH_RUN_O.timer_f        = SLEEP_MODE_I & ~STOP_MODE_I
                                    & core.sleep_gate[`BIT_TIMER_F];
      PERIPH_RUN_O.timer_e        = SLEEP_MODE_I & ~STOP_MODE_I
                                    & core.sleep_gate[`BIT_TIMER_E];
      PERIPH_RUN_O.timer_d        = SLEEP_MODE_I & ~STOP_MODE_I
                                    & core.sleep_gate[`BIT_TIMER_D];
      PERIPH_RUN_O.sync_serial_a  = SLEEP_MODE_I & ~STOP_MODE_I
                                    & core.sleep_gate[`BIT_SYNC_SER];
      PERIPH_RUN_O.advanced_timer = SLEEP_MODE_I & ~STOP_MODE_I
                                    & core.sleep_gate[`BIT_ADV_TIMER];
      // these keep running in stop as well
      PERIPH_RUN_O.serial_port_a  = core.sleep_gate[`BIT_SERIAL_A];
      PERIPH_RUN_O.sys_config     = core.sleep_gate[`BIT_SYS_CFG];
    end
  end

  // ----------------------------------------------------------------
  // kernel sources and backup controls out
  // ----------------------------------------------------------------
  // converter and two-wire code 11 is reserved, consumer treats as off
  assign KERNEL_SEL_O.converter_clk_source     =
    core.kernel_sel[`POS_CONVERTER_SRC +: 2];
  assign KERNEL_SEL_O.audio_serial_clk_source  =
    core.kernel_sel[`POS_AUDIO_SRC +: 2];
  assign KERNEL_SEL_O.two_wire_clk_source      =
    core.kernel_sel[`POS_TWO_WIRE_SRC +: 2];
  assign KERNEL_SEL_O.serial_port_b_clk_source =
    core.kernel_sel[`POS_SERIAL_B_SRC +: 2];
  assign KERNEL_SEL_O.serial_port_a_clk_source =
    core.kernel_sel[`POS_SERIAL_A_SRC +: 2];

  // calendar source code drives the mux, 00 means no clock
  assign BACKUP_CTRL_O  = bk;
  assign XTAL_READY_O   = ready;
  assign DOMAIN_RESET_O = bk.backup_domain_sw_reset;

endmodule : sleep_clk_gate_kernel_sel_rtc

// ---- tb/sleep_clk_gate_assertions.sv ----
/* assertions on the ports of the clock control slice.
   assumes: bound to the top module by the bind at the foot. */
`timescale 1ns/100ps
module sleep_clk_gate_assertions #(
  parameter int ADDR_W = 12
) (
  input wire logic                                CLK_SYS_I,             // clock
  input wire logic                                RESETN_I,              // reset
  input wire logic                                PSEL_I,                // select
  input wire logic                                PENABLE_I,             // enable
  input wire logic                                PWRITE_I,              // write
  input wire logic [ADDR_W-1:0]                   PADDR_I,               // address
  input wire logic                                PREADY_O,              // ready
  input wire logic                                DOMAIN_WRITE_UNLOCK_I, // unlock
  input wire logic                                STOP_MODE_I,           // stop
  input wire sleep_clk_gate_pkg::periph_run_type  PERIPH_RUN_O,          // run
  input wire sleep_clk_gate_pkg::backup_ctrl_type BACKUP_CTRL_O          // backup
);
  // ----------------------------------------------------------------
  // bus, stop gating and backup domain properties
  // ----------------------------------------------------------------
  sleep_clk_gate_pkg::backup_ctrl_type b;
  assign b = BACKUP_CTRL_O;
  // access phase, and a backup write completing in it
  sequence s_acc;
    PSEL_I && PENABLE_I;
  endsequence
  sequence s_bkp_wr;
    s_acc ##0 PREADY_O && PWRITE_I && PADDR_I == 12'h05c;
  endsequence
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!RESETN_I);
  a_gate_no_wait: assert property (PSEL_I && PADDR_I != 12'h05c |-> PREADY_O)
    else $error("gate or kernel access waited");
  a_backup_wait: assert property (s_acc |-> ##[0:3] PREADY_O)
    else $error("backup access over three waits");
  a_locked_write: assert property (s_bkp_wr ##0 !DOMAIN_WRITE_UNLOCK_I
    |=> $stable(b[11:10]) && $stable(b.crystal_enable)) else $error("locked write landed");
  a_stop_gate: assert property (STOP_MODE_I |-> {PERIPH_RUN_O[8:4], PERIPH_RUN_O[2:1]} == 7'h0)
    else $error("sleep only clock runs in stop");
  a_bypass_guard: assert property ($changed(b.crystal_bypass) && !$past(b.backup_domain_sw_reset)
    |-> !$past(b.crystal_enable)) else $error("bypass changed while crystal on");
  a_monitor_sticky: assert property ($fell(b.crystal_monitor_enable)
    |-> $past(b.crystal_failure_flag) || $past(b.backup_domain_sw_reset)) else $error("monitor cleared");
  a_source_lock: assert property ($changed(b.calendar_clock_source) |->
    $past(b.calendar_clock_source) == 2'b00 || $past(b.crystal_failure_flag)
    || $past(b.backup_domain_sw_reset)) else $error("locked source changed");
  a_reset_clear: assert property (b.backup_domain_sw_reset [*2] |-> !b.crystal_enable
    && !b.calendar_clock_enable && b.calendar_clock_source == 2'b00) else $error("domain not held");
endmodule : sleep_clk_gate_assertions

bind sleep_clk_gate_kernel_sel_rtc sleep_clk_gate_assertions #(.ADDR_W(ADDR_W)) u_chk (
  .CLK_SYS_I(CLK_SYS_I), .RESETN_I(RESETN_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
  .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PREADY_O(PREADY_O),
  .DOMAIN_WRITE_UNLOCK_I(DOMAIN_WRITE_UNLOCK_I), .STOP_MODE_I(STOP_MODE_I),
  .PERIPH_RUN_O(PERIPH_RUN_O), .BACKUP_CTRL_O(BACKUP_CTRL_O));

// ---- tb/tb_top.sv ----
/* self-checking bench for the clock control slice.
   assumes: design files and checker compiled before it. */
`timescale 1ns/100ps
module tb_top;
  logic        clk, rst_n, porn_n, psel, penable, pwrite, unlock, sleep, stop, stable, fail, xclk;
  logic        pready, pslverr, rdy, dres;
  logic [11:0] paddr;
  logic [3:0]  pstrb;
  logic [31:0] pwdata, prdata, g;
  logic [32:0] notes[$];
  int          num_errors = 0;
  int          checked = 0;
  sleep_clk_gate_pkg::periph_run_type run;
  sleep_clk_gate_pkg::kernel_sel_type ksel;
  sleep_clk_gate_pkg::backup_ctrl_type bko;

  sleep_clk_gate_kernel_sel_rtc u_sleep_clk_gate_kernel_sel_rtc (
    .CLK_SYS_I(clk), .RESETN_I(rst_n), .BKP_PORN_I(porn_n), .PSEL_I(psel),
    .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PSTRB_I(pstrb), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .DOMAIN_WRITE_UNLOCK_I(unlock), .SLEEP_MODE_I(sleep), .STOP_MODE_I(stop),
    .XTAL_STABLE_I(stable), .XTAL_CLK_I(xclk), .XTAL_FAIL_I(fail), .PERIPH_RUN_O(run),
    .KERNEL_SEL_O(ksel), .BACKUP_CTRL_O(bko), .XTAL_READY_O(rdy), .DOMAIN_RESET_O(dres));

  // ----------------------------------------------------------------
  // compare, verdict and bus tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : check
  task automatic results;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results
  // one apb transfer, held until ready, bounded wait
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      num_errors++;
      results();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  // read with the expected error bit and data noted first
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    notes.push_back(e);
    apb(1'b0, a, 32'h0, 4'h0);
  endtask : rd

  // clock and read monitor
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite)
      check({pslverr, prdata}, notes.pop_front());
  end

  // main sequence
  initial begin
    {rst_n, porn_n, psel, penable, pwrite, unlock, sleep, stop, stable, fail, xclk} = '0;
    paddr  = '0;
    pwdata = '0;
    pstrb  = '0;
    void'($urandom(51));
    repeat (4) @(posedge clk);
    rst_n  <= 1'b1;
    porn_n <= 1'b1;
    @(posedge clk);
    rd(12'h050, 33'h0017d801);
    rd(12'h054, 33'h0);
    rd(12'h05c, 33'h0);
    rd(12'h058, 33'h100000000);
    g = $urandom;
    apb(1'b1, 12'h050, g, 4'hf);
    apb(1'b1, 12'h050, ~g, 4'h2);
    g = {g[31:16], ~g[15:8], g[7:0]} & 32'h0017d801;
    rd(12'h050, {1'b0, g});
    sleep <= 1'b1;
    @(negedge clk);
    check({24'h0, run}, {24'h0, g[20], g[18:14], g[12:11], g[0]});
    @(posedge clk);
    sleep <= 1'b0;
    stop  <= 1'b1;
    @(negedge clk);
    check({24'h0, run}, {29'h0, g[14], 2'b0, g[0]});
    @(posedge clk);
    stop <= 1'b0;
    @(negedge clk);
    check({24'h0, run}, 33'h1ff);
    @(posedge clk);
    for (int c = 0; c < 4; c++) begin
      g = {16{c[1:0]}};
      apb(1'b1, 12'h054, g, 4'hf);
      rd(12'h054, {1'b0, g & 32'hc000f00f});
      check({23'h0, ksel}, {23'h0, {5{c[1:0]}}});
    end
    apb(1'b1, 12'h05c, 32'h03000101, 4'hf);
    rd(12'h05c, 33'h0);
    unlock <= 1'b1;
    apb(1'b1, 12'h05c, 32'h03008119, 4'hf);
    apb(1'b1, 12'h05c, 32'h0300821d, 4'hf);
    rd(12'h05c, 33'h03008119);
    stable <= 1'b1;
    repeat (6) @(posedge clk);
    rd(12'h05c, 33'h0300811b);
    check({20'h0, rdy, bko}, 33'h1d4d);
    // clear the enable, ready drops on the sixth crystal rise
    apb(1'b1, 12'h05c, 32'h03008118, 4'hf);
    for (int k = 0; k < 6; k++) begin
      check({32'h0, rdy}, 33'h1);
      xclk <= 1'b1;
      repeat (3) @(posedge clk);
      xclk <= 1'b0;
      repeat (3) @(posedge clk);
    end
    check({32'h0, rdy}, 33'h0);
    apb(1'b1, 12'h05c, 32'h03008119, 4'hf);
    apb(1'b1, 12'h05c, 32'h03008139, 4'hf);
    apb(1'b1, 12'h05c, 32'h03008119, 4'hf);
    rd(12'h05c, 33'h0300813b);
    fail <= 1'b1;
    repeat (5) @(posedge clk);
    rd(12'h05c, 33'h0300817b);
    fail <= 1'b0;
    apb(1'b1, 12'h05c, 32'h03010000, 4'hf);
    check({32'h0, dres}, 33'h1);
    apb(1'b1, 12'h05c, 32'h03000000, 4'hf);
    rd(12'h05c, 33'h03000000);
    apb(1'b1, 12'h05c, 32'h03000004, 4'hf);
    rd(12'h05c, 33'h03000004);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(12'h05c, 33'h03000004);
    rd(12'h050, 33'h0017d801);
    results();
  end
endmodule : tb_top
